// ---- logic/mbdos_top.sv ----
// Data operand stage of a memory self-test controller with APB registers
// Behaviour
// - Polarity bit 8 selects plain source value when clear, inverse when set.
// - Read returns are compared against the source, plain or inverted per polarity.
// - Write data is the source value, plain or inverted per polarity.
// - Read-and-write compares with polarity, writes with opposite polarity.
// - Other transaction types use unmodified polarity for read and write.
// - Polarity ignored when read data is saved into X, Y or mask.
// - Protection check operations use polarity to pick the examined bit.
// - Bitmap mode, check or xor op, fixed pattern: address direction replaces polarity.
// - Source field 7:6 picks X, Y, mask, else fixed pattern.
// - Transaction field 5:4: none, read, write, read then write.
// - Check-read mismatch sets the test fail flag.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mbdos_defines.svh"
module mbdos_top import mbdos_pkg::*; #(
    parameter int DW = 32,
    parameter int AW = 8
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    output logic               irq,
    output logic               mem_re,
    output logic               mem_we,
    output logic      [DW-1:0] mem_wdata,
    input  wire logic          mem_rvalid,
    input  wire logic [DW-1:0] mem_rdata
);
    mbdos_state_e st_q, st_d;
    logic [`MBDOS_INSTR_W-1:0] instr_q, instr_d;
    logic [DW-1:0] x_q, x_d, y_q, y_d, m_q, m_d, fp_q, fp_d, wdat_q, wdat_d;
    logic [2:0]  ctrl_q, ctrl_d;
    logic [1:0]  sts_q, sts_d, mask_q, mask_d, sts_set;
    logic        re_q, re_d, we_q, we_d;
    logic        wr_en, rd_en, hit, ovr, eff_pol, rd_pol, wr_pol, chk_fail, exec;
    logic [1:0]  src;
    logic [3:0]  op;
    logic [7:0]  a8;
    mbdos_transaction_type_e trn;
    logic [DW-1:0] rd_val, wr_val, ign;

    // Instruction fields
    assign src = instr_q[`MBDOS_SRC_HI:`MBDOS_SRC_LO];
    assign op  = instr_q[`MBDOS_OP_HI:`MBDOS_OP_LO];
    assign trn = mbdos_transaction_type_e'(instr_q[`MBDOS_TRN_HI:`MBDOS_TRN_LO]);
    assign a8  = 8'(paddr);

    // Effective polarity for compare and write
    always_comb begin
        ovr = ctrl_q[`MBDOS_CTRL_BAM] && (op == `MBDOS_OP_CHECK_READ || op == `MBDOS_OP_XOR_DATA)
              && src == `MBDOS_SRC_FP;
        eff_pol = ovr ? ctrl_q[`MBDOS_CTRL_ADIR] : instr_q[`MBDOS_POL_BIT];
        rd_pol  = eff_pol;
        wr_pol  = (trn == MBDOS_TR_RDWR) ? ~eff_pol : eff_pol;
    end

    // Mask bits drop out of the compare unless masking is disabled
    assign ign = ctrl_q[`MBDOS_CTRL_DATA_MASK_DISABLE] ? '0 : m_q;

    mbdos_src_sel #(.DW(DW)) u_src (
        .clk                (clk),
        .rst_n              (rst_n),
        .data_source_select (src),
        .x_data             (x_q),
        .y_data             (y_q),
        .mask_data          (m_q),
        .fixed_pattern      (fp_q),
        .rd_pol             (rd_pol),
        .wr_pol             (wr_pol),
        .rd_value           (rd_val),
        .wr_value           (wr_val)
    );

    mbdos_rd_check #(.DW(DW)) u_chk (
        .clk            (clk),
        .rst_n          (rst_n),
        .operation_code (op),
        .test_read_data (mem_rdata),
        .expect_value   (rd_val),
        .ignore_bits    (ign),
        .data_polarity  (instr_q[`MBDOS_POL_BIT]),
        .check_fail     (chk_fail)
    );

    // APB decode, zero wait states
    always_comb begin
        wr_en = psel && penable && pwrite;
        rd_en = psel && penable && !pwrite;
        hit   = (a8 <= `MBDOS_OFF_EXEC) && (a8[1:0] == 2'b00);
        exec  = wr_en && a8 == `MBDOS_OFF_EXEC && pwdata[0] && st_q == MBDOS_ST_IDLE;
    end
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;

    // Read mux
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_en) begin
            unique case (a8)
                `MBDOS_OFF_INSTR: prdata = 32'(instr_q);
                `MBDOS_OFF_XDAT:  prdata = 32'(x_q);
                `MBDOS_OFF_YDAT:  prdata = 32'(y_q);
                `MBDOS_OFF_MDAT:  prdata = 32'(m_q);
                `MBDOS_OFF_FIXP:  prdata = 32'(fp_q);
                `MBDOS_OFF_CTRL:  prdata = 32'({st_q == MBDOS_ST_WAIT, ctrl_q});
                `MBDOS_OFF_STS:   prdata = 32'(sts_q);
                `MBDOS_OFF_MASK:  prdata = 32'(mask_q);
                default:          prdata = 32'h0000_0000;
            endcase
        end
    end

    // Next state: registers, sequencer, memory strobes, status
    always_comb begin
        st_d    = st_q;
        instr_d = instr_q;
        x_d     = x_q;
        y_d     = y_q;
        m_d     = m_q;
        fp_d    = fp_q;
        ctrl_d  = ctrl_q;
        mask_d  = mask_q;
        wdat_d  = wdat_q;
        re_d    = 1'b0;
        we_d    = 1'b0;
        sts_set = 2'b00;
        // Register writes; instruction locked while busy
        if (wr_en) begin
            unique case (a8)
                `MBDOS_OFF_INSTR: if (st_q == MBDOS_ST_IDLE) instr_d = pwdata[`MBDOS_INSTR_W-1:0];
                `MBDOS_OFF_XDAT:  x_d    = DW'(pwdata);
                `MBDOS_OFF_YDAT:  y_d    = DW'(pwdata);
                `MBDOS_OFF_MDAT:  m_d    = DW'(pwdata);
                `MBDOS_OFF_FIXP:  fp_d   = DW'(pwdata);
                `MBDOS_OFF_CTRL:  ctrl_d = pwdata[2:0];
                `MBDOS_OFF_MASK:  mask_d = pwdata[1:0];
                default: ;
            endcase
        end
        // Sequencer: start on execute, finish on read return
        unique case (st_q)
            MBDOS_ST_IDLE: begin
                if (exec) begin
                    // Writes issue at once, reads wait for the return
                    unique case (trn)
                        MBDOS_TR_NONE: sts_set[`MBDOS_STS_DONE] = 1'b1;
                        MBDOS_TR_WRITE: begin
                            we_d   = 1'b1;
                            wdat_d = wr_val;
                            sts_set[`MBDOS_STS_DONE] = 1'b1;
                        end
                        default: begin
                            re_d = 1'b1;
                            st_d = MBDOS_ST_WAIT;
                        end
                    endcase
                end
            end
            MBDOS_ST_WAIT: begin
                if (mem_rvalid) begin
                    if (op == `MBDOS_OP_SAVERD || op == `MBDOS_OP_WAITRU) begin
                        // Raw data stored, polarity not applied
                        unique case (src)
                            `MBDOS_SRC_X: x_d = mem_rdata;
                            `MBDOS_SRC_Y: y_d = mem_rdata;
                            `MBDOS_SRC_M: m_d = mem_rdata;
                            default: ;
                        endcase
                    end
                    sts_set[`MBDOS_STS_FAIL] = chk_fail;
                    if (trn == MBDOS_TR_RDWR) begin
                        we_d   = 1'b1;
                        wdat_d = wr_val;
                    end
                    sts_set[`MBDOS_STS_DONE] = 1'b1;
                    st_d = MBDOS_ST_IDLE;
                end
            end
        endcase
        // Set wins over write-one-to-clear
        sts_d = sts_q & ~((wr_en && a8 == `MBDOS_OFF_STS) ? pwdata[1:0] : 2'b00);
        sts_d = sts_d | sts_set;
    end

    // State registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q    <= MBDOS_ST_IDLE;
            instr_q <= `MBDOS_INSTR_RST;
            x_q     <= '0;
            y_q     <= '0;
            m_q     <= '0;
            fp_q    <= '0;
            wdat_q  <= '0;
            ctrl_q  <= `MBDOS_CTRL_RST;
            sts_q   <= `MBDOS_STS_RST;
            mask_q  <= 2'h0;
            re_q    <= 1'b0;
            we_q    <= 1'b0;
        end else begin
            st_q    <= st_d;
            instr_q <= instr_d;
            x_q     <= x_d;
            y_q     <= y_d;
            m_q     <= m_d;
            fp_q    <= fp_d;
            wdat_q  <= wdat_d;
            ctrl_q  <= ctrl_d;
            sts_q   <= sts_d;
            mask_q  <= mask_d;
            re_q    <= re_d;
            we_q    <= we_d;
        end
    end

    // Outputs
    assign mem_re    = re_q;
    assign mem_we    = we_q;
    assign mem_wdata = wdat_q;
    assign irq       = |(sts_q & mask_q);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Sequencer and data path checks
    a_write_data: assert property (exec && trn == MBDOS_TR_WRITE
                                   |=> mem_we && mem_wdata == $past(wr_val))
        else $error("write data not taken from source");
    a_rw_opposite: assert property (st_q == MBDOS_ST_WAIT && mem_rvalid && trn == MBDOS_TR_RDWR
                                    |=> mem_we && mem_wdata == ~$past(rd_val))
        else $error("read-write data polarity not opposite");
    a_pol_same: assert property (trn != MBDOS_TR_RDWR |-> wr_pol == rd_pol)
        else $error("polarity modified outside read-write");
    a_bam_override: assert property (ovr |-> rd_pol == ctrl_q[`MBDOS_CTRL_ADIR])
        else $error("address direction did not replace polarity");
    a_save_raw: assert property (st_q == MBDOS_ST_WAIT && mem_rvalid && op == `MBDOS_OP_SAVERD
                                 && src == `MBDOS_SRC_X |=> x_q == $past(mem_rdata))
        else $error("saved data altered by polarity");
    a_fail_flag: assert property (st_q == MBDOS_ST_WAIT && mem_rvalid && chk_fail
                                  |=> sts_q[`MBDOS_STS_FAIL])
        else $error("mismatch did not set fail flag");
    a_no_transaction_type: assert property (exec && trn == MBDOS_TR_NONE
                                 |=> !mem_re && !mem_we && st_q == MBDOS_ST_IDLE)
        else $error("transaction issued for none");
    a_read_issue: assert property (exec && trn == MBDOS_TR_READ
                                   |=> mem_re ##1 !mem_re && st_q == MBDOS_ST_WAIT)
        else $error("read strobe not a single pulse");
    a_irq_done: assert property (st_q == MBDOS_ST_WAIT && mem_rvalid && mask_q[`MBDOS_STS_DONE]
                                 |=> irq)
        else $error("done interrupt missing");

    // Strobes last one cycle each, every instruction reports done
    a_re_pulse: assert property (mem_re |=> !mem_re)
        else $error("read strobe held longer than one cycle");
    a_we_pulse: assert property (mem_we |=> !mem_we)
        else $error("write strobe held longer than one cycle");
    a_none_done: assert property (exec && trn == MBDOS_TR_NONE |=> sts_q[`MBDOS_STS_DONE])
        else $error("empty transaction did not report done");
    a_wait_hold: assert property (st_q == MBDOS_ST_WAIT && !mem_rvalid |=> st_q == MBDOS_ST_WAIT)
        else $error("sequencer left wait without a read return");
    a_read_done: assert property (st_q == MBDOS_ST_WAIT && mem_rvalid
                                  |=> st_q == MBDOS_ST_IDLE && sts_q[`MBDOS_STS_DONE])
        else $error("read return did not finish the instruction");

    // Polarity, saved data and compare against the selected source
    a_pol_plain: assert property (!ovr && trn != MBDOS_TR_RDWR |-> wr_pol == instr_q[`MBDOS_POL_BIT])
        else $error("write polarity differs from instruction bit");
    a_save_wait: assert property (st_q == MBDOS_ST_WAIT && mem_rvalid && op == `MBDOS_OP_WAITRU
                                  && src == `MBDOS_SRC_Y |=> y_q == $past(mem_rdata))
        else $error("wait-updated save altered the data");
    a_chk_cmp: assert property (st_q == MBDOS_ST_WAIT && op == `MBDOS_OP_CHECK_READ && ctrl_q[`MBDOS_CTRL_DATA_MASK_DISABLE]
                                |-> chk_fail == (mem_rdata != rd_val))
        else $error("compare result does not match data");

    // Register side: refused offsets, busy bit, fail flag clear
    a_slv_err: assert property (psel && penable && a8 > `MBDOS_OFF_EXEC |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped offset not refused");
    a_busy_bit: assert property (rd_en && a8 == `MBDOS_OFF_CTRL
                                 |-> prdata[`MBDOS_CTRL_BUSY] == (st_q == MBDOS_ST_WAIT))
        else $error("busy bit does not follow the sequencer");
    a_sts_clear: assert property (wr_en && a8 == `MBDOS_OFF_STS && pwdata[`MBDOS_STS_FAIL]
                                  && !(st_q == MBDOS_ST_WAIT && mem_rvalid) |=> !sts_q[`MBDOS_STS_FAIL])
        else $error("fail flag not cleared by write one");

    // Main scenarios
    c_rdwr: cover property (st_q == MBDOS_ST_WAIT && mem_rvalid && trn == MBDOS_TR_RDWR);
    c_fail: cover property (st_q == MBDOS_ST_WAIT && mem_rvalid && chk_fail);
    c_bam: cover property (exec && ovr);
    c_save: cover property (st_q == MBDOS_ST_WAIT && mem_rvalid && op == `MBDOS_OP_SAVERD);
    c_pchk: cover property (exec && op == `MBDOS_OP_PCHKUE);
endmodule
`default_nettype wire

// ---- logic/mbdos_defines.svh ----
// Register map, field positions, codes and reset values of the data operand block
`ifndef MBDOS_DEFINES_SVH
`define MBDOS_DEFINES_SVH
`define MBDOS_OFF_INSTR  8'h00
`define MBDOS_OFF_XDAT   8'h04
`define MBDOS_OFF_YDAT   8'h08
`define MBDOS_OFF_MDAT   8'h0C
`define MBDOS_OFF_FIXP   8'h10
`define MBDOS_OFF_CTRL   8'h14
`define MBDOS_OFF_STS    8'h18
`define MBDOS_OFF_MASK   8'h1C
`define MBDOS_OFF_EXEC   8'h20
`define MBDOS_INSTR_W    13
`define MBDOS_INSTR_RST  13'h0000
`define MBDOS_POL_BIT    8
`define MBDOS_SRC_HI     7
`define MBDOS_SRC_LO     6
`define MBDOS_TRN_HI     5
`define MBDOS_TRN_LO     4
`define MBDOS_OP_HI      3
`define MBDOS_OP_LO      0
`define MBDOS_CTRL_BAM   0
`define MBDOS_CTRL_ADIR  1
`define MBDOS_CTRL_DATA_MASK_DISABLE 2
`define MBDOS_CTRL_BUSY  3
`define MBDOS_CTRL_RST   3'h0
`define MBDOS_STS_DONE   0
`define MBDOS_STS_FAIL   1
`define MBDOS_STS_RST    2'h0
`define MBDOS_SRC_X      2'h0
`define MBDOS_SRC_Y      2'h1
`define MBDOS_SRC_M      2'h2
`define MBDOS_SRC_FP     2'h3
`define MBDOS_OP_CHECK_READ    4'h0
`define MBDOS_OP_SAVERD  4'h2
`define MBDOS_OP_WAITRU  4'h3
`define MBDOS_OP_LOOPL   4'h4
`define MBDOS_OP_LOOPLAH 4'h6
`define MBDOS_OP_PCHKCE  4'hC
`define MBDOS_OP_PCHKUE  4'hD
`define MBDOS_OP_XOR_DATA    4'hE
`endif

// ---- logic/mbdos_pkg.sv ----
// Types shared by the data operand block
package mbdos_pkg;
    typedef enum logic [0:0] {
        MBDOS_ST_IDLE = 1'b0,
        MBDOS_ST_WAIT = 1'b1
    } mbdos_state_e;
    typedef enum logic [1:0] {
        MBDOS_TR_NONE  = 2'b00,
        MBDOS_TR_READ  = 2'b01,
        MBDOS_TR_WRITE = 2'b10,
        MBDOS_TR_RDWR  = 2'b11
    } mbdos_transaction_type_e;
endpackage

// ---- logic/mbdos_src_sel.sv ----
// Data source multiplexer with read and write polarity
`timescale 1ns/1ps
`default_nettype none
`include "mbdos_defines.svh"
module mbdos_src_sel import mbdos_pkg::*; #(
    parameter int DW = 32
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic [1:0]    data_source_select,
    input  wire logic [DW-1:0] x_data,
    input  wire logic [DW-1:0] y_data,
    input  wire logic [DW-1:0] mask_data,
    input  wire logic [DW-1:0] fixed_pattern,
    input  wire logic          rd_pol,
    input  wire logic          wr_pol,
    output logic      [DW-1:0] rd_value,
    output logic      [DW-1:0] wr_value
);
    logic [DW-1:0] plain;

    // Source pick by two-bit select
    function automatic logic [DW-1:0] pick(input logic [1:0] s, input logic [DW-1:0] a,
                                           input logic [DW-1:0] b, input logic [DW-1:0] c,
                                           input logic [DW-1:0] d);
        unique case (s)
            `MBDOS_SRC_X: pick = a;
            `MBDOS_SRC_Y: pick = b;
            `MBDOS_SRC_M: pick = c;
            default:      pick = d;
        endcase
    endfunction

    // Full width complement when polarity set
    always_comb begin
        plain    = pick(data_source_select, x_data, y_data, mask_data, fixed_pattern);
        rd_value = rd_pol ? ~plain : plain;
        wr_value = wr_pol ? ~plain : plain;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_src_pick: assert property (data_source_select == `MBDOS_SRC_Y |-> plain == y_data)
        else $error("source select does not give y register");
    a_pol_invert: assert property (rd_pol |-> rd_value == ~plain)
        else $error("read value not a full complement");
endmodule
`default_nettype wire

// ---- logic/mbdos_rd_check.sv ----
// Read data comparison and protection check
`timescale 1ns/1ps
`default_nettype none
`include "mbdos_defines.svh"
module mbdos_rd_check import mbdos_pkg::*; #(
    parameter int DW = 32
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic [3:0]    operation_code,
    input  wire logic [DW-1:0] test_read_data,
    input  wire logic [DW-1:0] expect_value,
    input  wire logic [DW-1:0] ignore_bits,
    input  wire logic          data_polarity,
    output logic               check_fail
);
    logic mismatch;
    logic pchk_hit;

    // Operations that compare read data
    function automatic logic is_check(input logic [3:0] op);
        is_check = (op == `MBDOS_OP_CHECK_READ) || (op >= `MBDOS_OP_LOOPL && op <= `MBDOS_OP_LOOPLAH);
    endfunction

    // Compare and error flag pick
    always_comb begin
        mismatch   = |((test_read_data ^ expect_value) & ~ignore_bits);
        pchk_hit   = test_read_data[data_polarity];
        check_fail = (is_check(operation_code) && mismatch)
                   || ((operation_code == `MBDOS_OP_PCHKCE || operation_code == `MBDOS_OP_PCHKUE) && pchk_hit);
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_pchk_bit: assert property (operation_code == `MBDOS_OP_PCHKUE && data_polarity
                                 |-> check_fail == test_read_data[1])
        else $error("protection check examined wrong bit");
endmodule
`default_nettype wire

// ---- dv/mbdos_mem_model.sv ----
// Behavioural memory array on the far side of the test interface
`timescale 1ns/1ps
`default_nettype none
module mbdos_mem_model #(
    parameter int DW = 32
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          mem_re,
    input  wire logic [DW-1:0] rsp_data,
    input  wire logic [3:0]    rsp_delay,
    output logic               mem_rvalid,
    output logic      [DW-1:0] mem_rdata
);
    logic [3:0] cnt_q;
    // Read return after zero or more idle cycles; data churns when not valid
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q      <= 4'h0;
            mem_rvalid <= 1'b0;
            mem_rdata  <= '0;
        end else begin
            mem_rvalid <= 1'b0;
            mem_rdata  <= ~mem_rdata;
            if (mem_re && rsp_delay == 4'h0) begin
                mem_rvalid <= 1'b1;
                mem_rdata  <= rsp_data;
            end else if (mem_re) begin
                cnt_q <= rsp_delay;
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    mem_rvalid <= 1'b1;
                    mem_rdata  <= rsp_data;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- dv/mbdos_top_bench.sv ----
// Self-checking bench for the data operand stage
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check_val(64'(g), 64'(e))
module mbdos_top_bench import mbdos_pkg::*;;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic        mem_re, mem_we, mem_rvalid;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, mem_wdata, mem_rdata, rsp_data, rd;
    logic [31:0] xv, yv, mv, fv;
    logic [3:0]  rsp_delay;
    logic [33:0] rq[$];
    logic [31:0] wq[$];
    int          n_mismatch, total_checks;
    int          n_re, n_re_exp;

    mbdos_top #(.DW(32), .AW(8)) mbdos_top_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .mem_re(mem_re), .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_rvalid(mem_rvalid),
        .mem_rdata(mem_rdata));
    mbdos_mem_model #(.DW(32)) mbdos_mem_model_inst (.clk(clk), .rst_n(rst_n), .mem_re(mem_re),
        .rsp_data(rsp_data), .rsp_delay(rsp_delay), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

    // Clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check_val(input logic [63:0] g, input logic [63:0] e);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic end_sim();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One APB transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_mismatch++;
            end_sim();
        end
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic err);
        rq.push_back({1'b1, err, e});
        apb(1'b0, a, 32'h0);
    endtask

    function automatic logic [12:0] ins(input logic p, input logic [1:0] s, input logic [1:0] t,
                                        input logic [3:0] op);
        return {4'h0, p, s, t, op};
    endfunction

    function automatic logic [31:0] sv(input int s);
        return s == 0 ? xv : s == 1 ? yv : s == 2 ? mv : fv;
    endfunction

    // Load and execute one instruction, wait for done, check and clear status
    task automatic run(input logic [12:0] i, input logic [31:0] rdat, input logic fail);
        int n;
        rsp_data  <= rdat;
        rsp_delay <= 4'($urandom_range(0, 4));
        if (i[4]) n_re_exp++;
        wr(8'h00, {19'h0, i});
        wr(8'h20, 32'h1);
        n = 0;
        do begin
            rq.push_back(34'h0);
            apb(1'b0, 8'h18, 32'h0);
            n++;
        end while (rd[0] !== 1'b1 && n < 30);
        if (rd[0] !== 1'b1) begin
            n_mismatch++;
            end_sim();
        end
        rdc(8'h18, {30'h0, fail, 1'b1}, 1'b0);
        wr(8'h18, 32'h3);
    endtask

    // Read data and error flag against the oldest note
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite) begin
            if (rq.size() == 0) begin
                `CHK(rq.size(), 1);
            end else if (rq[0][33]) begin
                `CHK(prdata, rq[0][31:0]);
                `CHK(pslverr, rq[0][32]);
                void'(rq.pop_front());
            end else begin
                void'(rq.pop_front());
            end
        end
    end

    // Memory write data against the oldest note
    always @(posedge clk) begin
        if (mem_we === 1'b1) begin
            if (wq.size() != 0) begin
                `CHK(mem_wdata, wq.pop_front());
            end else begin
                `CHK(mem_we, 1'b0);
            end
        end
    end

    // Read strobes counted against the reads issued
    always @(posedge clk) begin
        if (mem_re === 1'b1) begin
            n_re++;
        end
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rsp_data = 32'h0;
        rsp_delay = 4'h1;
        void'($urandom(32'hE0FEFD30));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rdc(8'h00, 32'h0, 1'b0);
        rdc(8'h14, 32'h0, 1'b0);
        rdc(8'h18, 32'h0, 1'b0);
        rdc(8'h24, 32'h0, 1'b1);
        xv = $urandom;
        yv = $urandom;
        mv = $urandom;
        fv = $urandom;
        wr(8'h04, xv);
        wr(8'h08, yv);
        wr(8'h0C, mv);
        wr(8'h10, fv);
        wr(8'h14, 32'h4);
        // Every source with both polarities on writes
        for (int s = 0; s < 4; s++) begin
            for (int p = 0; p < 2; p++) begin
                wq.push_back(p != 0 ? ~sv(s) : sv(s));
                run(ins(1'(p), 2'(s), 2'b10, 4'h0), 32'h0, 1'b0);
            end
        end
        // Read then write: compare per polarity, write with the opposite
        for (int p = 0; p < 2; p++) begin
            wq.push_back(p != 0 ? yv : ~yv);
            run(ins(1'(p), 2'b01, 2'b11, 4'h0), p != 0 ? ~yv : yv, 1'b0);
        end
        wq.push_back(~xv);
        run(ins(1'b0, 2'b00, 2'b11, 4'h0), xv ^ 32'h10, 1'b1);
        // Protection checks pick the bit by polarity
        run(ins(1'b0, 2'b11, 2'b01, 4'hC), 32'h1, 1'b1);
        run(ins(1'b1, 2'b11, 2'b01, 4'hC), 32'h1, 1'b0);
        run(ins(1'b1, 2'b11, 2'b01, 4'hD), 32'h2, 1'b1);
        // Mask register as data with masking off compares every bit; with masking on, masked bit 0 is ignored
        run(ins(1'b0, 2'b10, 2'b01, 4'h0), mv ^ 32'h1, 1'b1);
        wr(8'h14, 32'h0);
        wr(8'h0C, 32'h1);
        run(ins(1'b0, 2'b00, 2'b01, 4'h0), xv ^ 32'h1, 1'b0);
        // Loop operation compares like check-read
        run(ins(1'b0, 2'b01, 2'b01, 4'h5), yv ^ 32'h100, 1'b1);
        // Saved read data ignores polarity
        run(ins(1'b1, 2'b00, 2'b01, 4'h2), 32'hA5A50F0F, 1'b0);
        rdc(8'h04, 32'hA5A50F0F, 1'b0);
        run(ins(1'b1, 2'b01, 2'b01, 4'h3), 32'h5A5AF0F0, 1'b0);
        rdc(8'h08, 32'h5A5AF0F0, 1'b0);
        // Bitmap mode: direction bit stands in for polarity
        wr(8'h14, 32'h3);
        wq.push_back(~fv);
        run(ins(1'b0, 2'b11, 2'b10, 4'h0), 32'h0, 1'b0);
        wr(8'h14, 32'h1);
        wq.push_back(fv);
        run(ins(1'b1, 2'b11, 2'b10, 4'h0), 32'h0, 1'b0);
        wq.push_back(fv);
        run(ins(1'b1, 2'b11, 2'b10, 4'hE), 32'h0, 1'b0);
        // Interrupt raise, mask, unmask, clear
        wr(8'h1C, 32'h3);
        wr(8'h00, {19'h0, ins(1'b0, 2'b00, 2'b00, 4'h0)});
        wr(8'h20, 32'h1);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1);
        wr(8'h1C, 32'h2);
        @(negedge clk);
        `CHK(irq, 1'b0);
        wr(8'h1C, 32'h1);
        @(negedge clk);
        `CHK(irq, 1'b1);
        wr(8'h18, 32'h1);
        @(negedge clk);
        `CHK(irq, 1'b0);
        repeat (4) @(posedge clk);
        `CHK(n_re, n_re_exp);
        `CHK(wq.size(), 0);
        `CHK(rq.size(), 0);
        end_sim();
    end
endmodule
`default_nettype wire
